/* pkg/tfs_pkg.sv */
package tfs_pkg;
    // apb byte addresses
    localparam logic [11:0] TFS_ADDR_FMT      = 12'h000;
    localparam logic [11:0] TFS_ADDR_HALT     = 12'h004;
    localparam logic [11:0] TFS_ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] TFS_ADDR_IRQ_EN   = 12'h00C;
    localparam logic [11:0] TFS_ADDR_IRQ_CLR  = 12'h010;
    localparam logic [11:0] TFS_ADDR_CHAN     = 12'h014;
    // format switch control fields
    localparam int TFS_BIT_SWE = 7;
    localparam int TFS_BIT_SEL = 6;
    localparam int TFS_BIT_IE  = 5;
    localparam int TFS_BIT_IF  = 4;
    // module halt fields
    localparam int TFS_BIT_HALT0 = 4;
    localparam int TFS_BIT_HALT1 = 3;
    // reset values and clear field read value
    localparam logic [7:0]  TFS_FMT_RST  = 8'h0F;
    localparam logic [15:0] TFS_HALT_RST = 16'h3FFF;
    localparam logic [3:0]  TFS_CLR_READ = 4'hF;
    // latch clear codes
    localparam logic [3:0] TFS_CLR_CH0  = 4'h5;
    localparam logic [3:0] TFS_CLR_CH1  = 4'h6;
    localparam logic [3:0] TFS_CLR_BOTH = 4'h7;
    // interrupt status bit positions
    localparam int TFS_EV_SWITCH = 0;
    localparam int TFS_EV_BADCLR = 1;
    localparam int TFS_NUM_EV    = 2;
endpackage

/* core/tfs_core.sv */
module tfs_core
    import tfs_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system state
    input  wire logic        hw_standby,
    // link
    input  wire logic        scl_in,
    input  wire logic        chan0_cycle_busy,
    input  wire logic        chan1_cycle_busy,
    // to channels
    output logic             chan0_formatless,
    output logic             chan0_latch_clear,
    output logic             chan1_latch_clear,
    output logic             chan0_stopped,
    output logic             chan1_stopped,
    // interrupts
    output logic             switch_irq,
    output logic             irq
);
    typedef struct packed {
        logic [2:0]            scl_sync;
        logic                  auto_switch_enable;
        logic                  sel;
        logic                  sel_seen0;
        logic                  ie;
        logic                  flag;
        logic                  flag_seen1;
        logic [15:0]           halt;
        logic                  latch_clear_b0;
        logic                  latch_clear_b1;
        logic                  stop0;
        logic                  stop1;
        logic [TFS_NUM_EV-1:0] ev_stat;
        logic [TFS_NUM_EV-1:0] ev_en;
        logic                  irq;
        logic                  sw_irq;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  err;
    } tfs_state_s;

    tfs_state_s st_reg;
    tfs_state_s st_next;
    logic       wr;
    logic       rd;
    logic       scl_fall;
    logic [7:0] fmt_view;
    logic [3:0] code;
    logic       bad_code;
    logic [TFS_NUM_EV-1:0] ev_set;
    logic       auto_sw;
    logic       fmt_wr;

    default clocking dflt_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next  = st_reg;
        wr       = psel && penable && pwrite && !st_reg.ready;
        rd       = psel && penable && !pwrite && !st_reg.ready;
        code     = pwdata[3:0];
        bad_code = 1'b0;
        ev_set   = '0;
        // scl passes two flops before the edge detector
        st_next.scl_sync = {st_reg.scl_sync[1:0], scl_in};
        scl_fall = st_reg.scl_sync[2] && !st_reg.scl_sync[1];
        fmt_view = {st_reg.auto_switch_enable, st_reg.sel, st_reg.ie, st_reg.flag,
                    TFS_CLR_READ};
        st_next.ready = 1'b0;
        st_next.err   = 1'b0;
        st_next.latch_clear_b0  = 1'b0;
        st_next.latch_clear_b1  = 1'b0;
        // reading latches the values that allow later writes
        if (rd && paddr == TFS_ADDR_FMT) begin
            st_next.sel_seen0  = !st_reg.sel;
            st_next.flag_seen1 = st_reg.flag;
        end
        if (wr) begin
            unique case (paddr)
                TFS_ADDR_FMT: begin
                    st_next.auto_switch_enable = pwdata[TFS_BIT_SWE];
                    st_next.ie  = pwdata[TFS_BIT_IE];
                    if (!pwdata[TFS_BIT_SEL]) begin
                        st_next.sel = 1'b0;
                    end else if (st_reg.sel_seen0) begin
                        st_next.sel = 1'b1;
                    end
                    if (!pwdata[TFS_BIT_IF] && st_reg.flag_seen1) begin
                        st_next.flag = 1'b0;
                    end
                    st_next.sel_seen0  = 1'b0;
                    st_next.flag_seen1 = 1'b0;
                    // code is acted on, never stored
                    unique case (code)
                        TFS_CLR_CH0:  st_next.latch_clear_b0 = 1'b1;
                        TFS_CLR_CH1:  st_next.latch_clear_b1 = 1'b1;
                        TFS_CLR_BOTH: begin
                            st_next.latch_clear_b0 = 1'b1;
                            st_next.latch_clear_b1 = 1'b1;
                        end
                        default:      bad_code = !code[3];
                    endcase
                end
                TFS_ADDR_HALT: st_next.halt = pwdata[15:0];
                TFS_ADDR_IRQ_EN: st_next.ev_en = pwdata[TFS_NUM_EV-1:0];
                TFS_ADDR_IRQ_CLR:
                    st_next.ev_stat = st_reg.ev_stat
                                      & ~pwdata[TFS_NUM_EV-1:0];
                TFS_ADDR_FMT + 12'h018, TFS_ADDR_IRQ_STAT,
                TFS_ADDR_CHAN: ;
                default: st_next.err = 1'b1;
            endcase
        end
        if (rd) begin
            unique case (paddr)
                TFS_ADDR_FMT:      st_next.rdata = {24'h0, fmt_view};
                TFS_ADDR_HALT:     st_next.rdata = {16'h0, st_reg.halt};
                TFS_ADDR_IRQ_STAT: st_next.rdata = {30'h0, st_reg.ev_stat};
                TFS_ADDR_IRQ_EN:   st_next.rdata = {30'h0, st_reg.ev_en};
                TFS_ADDR_IRQ_CLR:  st_next.rdata = 32'h0;
                TFS_ADDR_CHAN:     st_next.rdata = {28'h0, st_reg.stop1,
                                       st_reg.stop0, 1'b0, st_reg.sel};
                TFS_ADDR_FMT + 12'h018: st_next.rdata = 32'h0;
                default: begin
                    st_next.rdata = 32'h0;
                    st_next.err   = 1'b1;
                end
            endcase
        end
        if (psel && penable && !st_reg.ready) begin
            st_next.ready = 1'b1;
        end
        // auto switch; hardware set beats software clear
        if (scl_fall && st_reg.auto_switch_enable) begin
            st_next.sel  = 1'b0;
            st_next.flag = 1'b1;
            ev_set[TFS_EV_SWITCH] = 1'b1;
        end
        ev_set[TFS_EV_BADCLR] = bad_code;
        st_next.ev_stat = st_next.ev_stat | ev_set;
        // halt takes effect only once the bus cycle is over
        if (st_reg.halt[TFS_BIT_HALT0] && !chan0_cycle_busy) begin
            st_next.stop0 = 1'b1;
        end else if (!st_reg.halt[TFS_BIT_HALT0]) begin
            st_next.stop0 = 1'b0;
        end
        if (st_reg.halt[TFS_BIT_HALT1] && !chan1_cycle_busy) begin
            st_next.stop1 = 1'b1;
        end else if (!st_reg.halt[TFS_BIT_HALT1]) begin
            st_next.stop1 = 1'b0;
        end
        st_next.sw_irq = st_next.flag && st_next.ie;
        st_next.irq    = |(st_next.ev_stat & st_next.ev_en);
        // hardware standby forces the format and halt registers to their reset values and clears sw_irq
        if (hw_standby) begin
            st_next.auto_switch_enable        = TFS_FMT_RST[TFS_BIT_SWE];
            st_next.sel        = TFS_FMT_RST[TFS_BIT_SEL];
            st_next.ie         = TFS_FMT_RST[TFS_BIT_IE];
            st_next.flag       = TFS_FMT_RST[TFS_BIT_IF];
            st_next.sel_seen0  = 1'b0;
            st_next.flag_seen1 = 1'b0;
            st_next.halt       = TFS_HALT_RST;
            st_next.sw_irq     = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg          <= '0;
            st_reg.scl_sync <= 3'b111;
            st_reg.auto_switch_enable      <= TFS_FMT_RST[TFS_BIT_SWE];
            st_reg.sel      <= TFS_FMT_RST[TFS_BIT_SEL];
            st_reg.ie       <= TFS_FMT_RST[TFS_BIT_IE];
            st_reg.flag     <= TFS_FMT_RST[TFS_BIT_IF];
            st_reg.halt     <= TFS_HALT_RST;
            st_reg.stop0    <= 1'b1;
            st_reg.stop1    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata            = st_reg.rdata;
    assign pready            = st_reg.ready;
    assign pslverr           = st_reg.err;
    assign chan0_formatless  = st_reg.sel;
    assign chan0_latch_clear = st_reg.latch_clear_b0;
    assign chan1_latch_clear = st_reg.latch_clear_b1;
    assign chan0_stopped     = st_reg.stop0;
    assign chan1_stopped     = st_reg.stop1;
    assign switch_irq        = st_reg.sw_irq;
    assign irq               = st_reg.irq;

    ////////////////////////////////////////////////////////////////////
    // helpers shared by the checks below
    assign auto_sw = scl_fall && st_reg.auto_switch_enable && !hw_standby;
    assign fmt_wr  = wr && paddr == TFS_ADDR_FMT;

    // automatic switching
    a_fall_sets_flag: assert property (
        auto_sw |=> st_reg.flag && !st_reg.sel)
        else $error("auto switch missed");

    a_fall_clears_sel: assert property (
        auto_sw |=> !chan0_formatless)
        else $error("formatless kept after scl fall");

    a_no_auto_off: assert property (
        (!st_reg.flag && !wr && (!st_reg.auto_switch_enable || !scl_fall)) |=> !st_reg.flag)
        else $error("flag set without auto switch");

    a_sel_kept_off: assert property (
        (st_reg.sel && !st_reg.auto_switch_enable && !wr && !hw_standby) |=> st_reg.sel)
        else $error("select dropped while auto switch off");

    a_sw_irq_set: assert property (
        (auto_sw && st_reg.ie && !fmt_wr) |=> switch_irq)
        else $error("switch request missing");

    a_stat_sets: assert property (
        auto_sw |=> st_reg.ev_stat[TFS_EV_SWITCH])
        else $error("switch status not set");

    // software access to the format register
    a_sel_set_guard: assert property (
        $rose(st_reg.sel) |-> $past(st_reg.sel_seen0) && $past(wr))
        else $error("select set without read");

    a_sel_write_zero: assert property (
        (fmt_wr && !pwdata[TFS_BIT_SEL]) |=> !st_reg.sel)
        else $error("select not cleared by write");

    a_flag_write_one: assert property (
        (st_reg.flag && fmt_wr && pwdata[TFS_BIT_IF] && !hw_standby)
        |=> st_reg.flag)
        else $error("flag lost on write of one");

    a_flag_clear_guard: assert property (
        $fell(st_reg.flag) |-> $past(hw_standby)
        || ($past(wr) && $past(st_reg.flag_seen1)))
        else $error("flag cleared without read");

    a_clr_reads_one: assert property (
        $past(rd && paddr == TFS_ADDR_FMT) |-> prdata[3:0] == TFS_CLR_READ)
        else $error("clear bits not read as one");

    a_clr_never_stored: assert property (
        fmt_view[3:0] == TFS_CLR_READ)
        else $error("clear code stored");

    // latch clear codes
    a_clr_pulse_one: assert property (
        chan0_latch_clear |=> !chan0_latch_clear)
        else $error("clear pulse too long");

    a_latch_clear_b1_pulse_one: assert property (
        chan1_latch_clear |=> !chan1_latch_clear)
        else $error("channel 1 clear pulse too long");

    a_clear0_cause: assert property (
        chan0_latch_clear |-> $past(fmt_wr))
        else $error("channel 0 clear without write");

    a_clear1_cause: assert property (
        chan1_latch_clear |-> $past(fmt_wr))
        else $error("channel 1 clear without write");

    a_code5_clear0: assert property (
        (fmt_wr && code == TFS_CLR_CH0)
        |=> chan0_latch_clear && !chan1_latch_clear)
        else $error("code for channel 0 wrong");

    a_code6_clear1: assert property (
        (fmt_wr && code == TFS_CLR_CH1)
        |=> chan1_latch_clear && !chan0_latch_clear)
        else $error("code for channel 1 wrong");

    a_code7_both: assert property (
        (fmt_wr && code == TFS_CLR_BOTH)
        |=> chan0_latch_clear && chan1_latch_clear)
        else $error("code for both channels wrong");

    a_bad_no_clear: assert property (
        (fmt_wr && code[3]) |=> !chan0_latch_clear && !chan1_latch_clear)
        else $error("invalid code cleared");

    a_bad_code_event: assert property (
        (fmt_wr && code < TFS_CLR_CH0) |=> st_reg.ev_stat[TFS_EV_BADCLR])
        else $error("prohibited code not reported");

    // interrupts and bus ready
    a_irq_follows: assert property (
        switch_irq == (st_reg.flag && st_reg.ie))
        else $error("switch irq wrong");

    a_irq_no_enable: assert property (
        !st_reg.ie |-> !switch_irq)
        else $error("switch irq while disabled");

    a_stat_sticky: assert property (
        (st_reg.ev_stat[TFS_EV_SWITCH] && !(wr && paddr == TFS_ADDR_IRQ_CLR))
        |=> st_reg.ev_stat[TFS_EV_SWITCH])
        else $error("switch status lost");

    a_irq_level: assert property (
        irq == |(st_reg.ev_stat & st_reg.ev_en))
        else $error("irq level wrong");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");

    // module halt
    a_halt_stop: assert property (
        (st_reg.halt[TFS_BIT_HALT1] && !chan1_cycle_busy) |=> chan1_stopped)
        else $error("channel 1 not stopped");

    a_halt0_stop: assert property (
        (st_reg.halt[TFS_BIT_HALT0] && !chan0_cycle_busy) |=> chan0_stopped)
        else $error("channel 0 not stopped");

    a_busy_holds0: assert property (
        (!chan0_stopped && chan0_cycle_busy) |=> !chan0_stopped)
        else $error("channel 0 stopped mid cycle");

    a_busy_holds1: assert property (
        (!chan1_stopped && chan1_cycle_busy) |=> !chan1_stopped)
        else $error("channel 1 stopped mid cycle");

    a_release0: assert property (
        !st_reg.halt[TFS_BIT_HALT0] |=> !chan0_stopped)
        else $error("channel 0 not released");

    a_release1: assert property (
        !st_reg.halt[TFS_BIT_HALT1] |=> !chan1_stopped)
        else $error("channel 1 not released");

    a_halt_hold: assert property (
        (!wr && !hw_standby) |=> $stable(st_reg.halt))
        else $error("halt register changed on its own");

    // hardware standby
    a_standby_fmt: assert property (
        hw_standby |=> fmt_view == TFS_FMT_RST)
        else $error("format register not reset by standby");

    a_standby_halt: assert property (
        hw_standby |=> st_reg.halt == TFS_HALT_RST)
        else $error("halt register not reset by standby");
endmodule

/* bench/tfs_scl_master.sv */
module tfs_scl_master (
    // control
    input  wire logic go,
    // link
    output logic      scl
);
    timeunit 1ns;
    timeprecision 1ps;
    // line idles at its pull-up level; clock runs only within a frame
    initial scl = 1'b1;
    always @(posedge go) begin
        #37;
        repeat (3) begin
            #100 scl = 1'b0;
            #100 scl = 1'b1;
        end
    end
endmodule

/* bench/twowire_format_switch_and_clear_tb_top.sv */
module twowire_format_switch_and_clear_tb_top
    import tfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic        e;
    } tfs_row_s;
    logic        pclk, presetn, psel, penable, pwrite, hw_standby;
    logic        go, scl, busy0, busy1, pready, pslverr, er;
    logic        fmtless, latch_clear_b0, latch_clear_b1, stop0, stop1, sw_irq, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, n_tests, cyc, n0, n1, b0, b1;
    tfs_row_s    rows [11] = '{
        '{0, TFS_ADDR_HALT, 32'h3FFF, 0}, '{1, TFS_ADDR_FMT, 32'h4F, 0},
        '{0, TFS_ADDR_FMT, 32'h0F, 0}, '{1, TFS_ADDR_FMT, 32'h4F, 0},
        '{0, TFS_ADDR_FMT, 32'h4F, 0}, '{1, TFS_ADDR_FMT, 32'h0F, 0},
        '{0, TFS_ADDR_FMT, 32'h0F, 0}, '{1, TFS_ADDR_HALT, 32'h0, 0},
        '{0, TFS_ADDR_HALT, 32'h0, 0}, '{0, 12'h020, 32'h0, 1},
        '{0, TFS_ADDR_IRQ_CLR, 32'h0, 0}};

    tfs_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_standby(hw_standby), .scl_in(scl),
        .chan0_cycle_busy(busy0), .chan1_cycle_busy(busy1),
        .chan0_formatless(fmtless), .chan0_latch_clear(latch_clear_b0),
        .chan1_latch_clear(latch_clear_b1), .chan0_stopped(stop0),
        .chan1_stopped(stop1), .switch_irq(sw_irq), .irq(irq));
    tfs_scl_master link (.go(go), .scl(scl));

    ////////////////////////////////////////////////////////////////
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        n0 += int'(latch_clear_b0);
        n1 += int'(latch_clear_b1);
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, g);
        n_tests++;
        if (g !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic fmt_rw(input logic [31:0] d, x);
        apb(0, TFS_ADDR_FMT, 32'h0);
        apb(1, TFS_ADDR_FMT, d);
        @(posedge pclk) go <= 1'b1;
        @(posedge pclk) go <= 1'b0;
        repeat (40) @(posedge pclk);
        apb(0, TFS_ADDR_FMT, 32'h0);
        chk("fmt", x, rd);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, hw_standby} = '0;
        {go, busy0, busy1, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk("rdata", rows[i].d, rd);
            chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
        end
        fmt_rw(32'h4F, 32'h4F);
        chk("formatless", 32'h1, {31'h0, fmtless});
        apb(1, TFS_ADDR_IRQ_EN, 32'h1);
        fmt_rw(32'hEF, 32'hBF);
        chk("formatless", 32'h0, {31'h0, fmtless});
        chk("switch_irq", 32'h1, {31'h0, sw_irq});
        chk("irq", 32'h1, {31'h0, irq});
        apb(1, TFS_ADDR_FMT, 32'hBF);
        apb(0, TFS_ADDR_FMT, 32'h0);
        chk("flag kept", 32'hBF, rd);
        apb(1, TFS_ADDR_FMT, 32'hAF);
        apb(0, TFS_ADDR_FMT, 32'h0);
        chk("flag clear", 32'hAF, rd);
        chk("switch_irq", 32'h0, {31'h0, sw_irq});
        apb(1, TFS_ADDR_IRQ_CLR, 32'h1);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        fmt_rw(32'hCF, 32'h9F);
        chk("switch_irq", 32'h0, {31'h0, sw_irq});
        for (int c = 5; c < 16; c++) begin
            b0 = n0;
            b1 = n1;
            apb(1, TFS_ADDR_FMT, 32'(c));
            repeat (2) @(posedge pclk);
            chk("clear0", 32'(c == 5 || c == 7), 32'(n0 - b0));
            chk("clear1", 32'(c == 6 || c == 7), 32'(n1 - b1));
        end
        busy0 <= 1'b1;
        busy1 <= 1'b1;
        apb(1, TFS_ADDR_HALT, 32'h18);
        repeat (4) @(posedge pclk);
        chk("stop busy", 32'h0, {30'h0, stop1, stop0});
        busy0 <= 1'b0;
        busy1 <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("stop idle", 32'h3, {30'h0, stop1, stop0});
        apb(1, TFS_ADDR_FMT, 32'hAF);
        hw_standby <= 1'b1;
        @(posedge pclk) hw_standby <= 1'b0;
        apb(0, TFS_ADDR_FMT, 32'h0);
        chk("fmt standby", 32'h0F, rd);
        apb(0, TFS_ADDR_HALT, 32'h0);
        chk("halt standby", 32'h3FFF, rd);
        apb(0, TFS_ADDR_CHAN, 32'h0);
        chk("chan", 32'hC, rd);
        apb(0, TFS_ADDR_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h1, rd);
        apb(1, TFS_ADDR_HALT, 32'h0);
        apb(1, TFS_ADDR_FMT, 32'hAF);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset stop", 32'h3, {30'h0, stop1, stop0});
        chk("reset irq", 32'h0, {30'h0, sw_irq, irq});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, TFS_ADDR_FMT, 32'h0);
        chk("fmt reset", 32'h0F, rd);
        conclude();
    end
endmodule
